/* hw/tws_slave.sv */
// two-wire slave unit with memory channels, register port and bus pins
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tws_slave #(
    parameter int ADDR_W = 12,
    parameter int PTR_W = 32,
    parameter int CNT_W = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // bus pins, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // memory port, one byte per access
    output logic mem_req,
    output logic mem_we,
    output logic [PTR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // event pulses
    output logic [5:0] event_pulse
);
    // pin synchronisers, three stages
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
        end
    end

    // bus conditions, sampled at 100 MHz so both 100 kHz and 400 kHz fit
    wire scl_rise = (scl_sync_reg[2] == scl_sync_reg[1]) && scl_sync_reg[2] && !scl_reg;
    wire scl_fall = (scl_sync_reg[2] == scl_sync_reg[1]) && !scl_sync_reg[2] && scl_reg;
    wire sda_rise = (sda_sync_reg[2] == sda_sync_reg[1]) && sda_sync_reg[2] && !sda_reg;
    wire sda_fall = (sda_sync_reg[2] == sda_sync_reg[1]) && !sda_sync_reg[2] && sda_reg;
    wire bus_start = sda_fall && scl_reg;
    wire bus_stop = sda_rise && scl_reg;

    // software registers
    logic enable_reg;
    logic [6:0] addr0_reg;
    logic [6:0] addr1_reg;
    logic [1:0] config_reg;
    logic [7:0] orc_reg;
    logic [1:0] shorts_reg;
    logic [PTR_W-1:0] rx_ptr_reg;
    logic [PTR_W-1:0] tx_ptr_reg;
    logic [CNT_W-1:0] rx_max_reg;
    logic [CNT_W-1:0] tx_max_reg;
    logic [5:0] events_reg;
    logic match_reg;

    // task strobes
    wire wr_stop = reg_write && (reg_addr == tws_pkg::OFS_TASK_STOP) && reg_wdata[0];
    wire wr_suspend = reg_write && (reg_addr == tws_pkg::OFS_TASK_SUSPEND) && reg_wdata[0];
    wire wr_resume = reg_write && (reg_addr == tws_pkg::OFS_TASK_RESUME) && reg_wdata[0];
    wire wr_prep_rx = reg_write && (reg_addr == tws_pkg::OFS_TASK_PREP_RX) && reg_wdata[0];
    wire wr_prep_tx = reg_write && (reg_addr == tws_pkg::OFS_TASK_PREP_TX) && reg_wdata[0];

    // transfer state
    tws_pkg::tws_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic dir_read_reg;
    logic tx_ready_reg;
    logic rx_ready_reg;
    logic suspended_reg;
    logic [PTR_W-1:0] cur_ptr_reg;
    logic [CNT_W-1:0] cur_max_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] rx_total_reg;
    logic [CNT_W-1:0] tx_total_reg;
    logic sda_hold_reg;
    logic scl_hold_reg;
    logic pend_stop_reg;
    logic mem_req_reg;
    logic mem_we_reg;
    logic [7:0] tx_byte_reg;
    logic [5:0] ev_pulse_reg;

    // address match against two configured addresses
    wire hit0 = config_reg[0] && (shift_reg[7:1] == addr0_reg);
    wire hit1 = config_reg[1] && (shift_reg[7:1] == addr1_reg);
    wire addr_hit = hit0 || hit1;
    wire in_frame = (state_reg == tws_pkg::TWS_ACTIVE) || (state_reg == tws_pkg::TWS_WAIT);
    // a stop task or bus stop only completes once the memory access is done
    wire finish = (pend_stop_reg || bus_stop || wr_stop) && !mem_req_reg;
    wire can_go = dir_read_reg ? tx_ready_reg : rx_ready_reg;
    wire over = (count_reg >= cur_max_reg);

    // register writes; software keeps address settings still while enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_reg <= 1'b0;
            addr0_reg <= 7'h00;
            addr1_reg <= 7'h00;
            config_reg <= tws_pkg::RST_CONFIG;
            orc_reg <= 8'h00;
            shorts_reg <= 2'h0;
            rx_ptr_reg <= '0;
            tx_ptr_reg <= '0;
            rx_max_reg <= '0;
            tx_max_reg <= '0;
        end else if (reg_write) begin
            if (reg_addr == tws_pkg::OFS_ENABLE) enable_reg <= (reg_wdata[3:0] == tws_pkg::ENABLE_ON);
            else if (reg_addr == tws_pkg::OFS_ADDR0) addr0_reg <= reg_wdata[6:0];
            else if (reg_addr == tws_pkg::OFS_ADDR1) addr1_reg <= reg_wdata[6:0];
            else if (reg_addr == tws_pkg::OFS_CONFIG) config_reg <= reg_wdata[1:0];
            else if (reg_addr == tws_pkg::OFS_ORC) orc_reg <= reg_wdata[7:0];
            else if (reg_addr == tws_pkg::OFS_SHORTS) shorts_reg <= reg_wdata[1:0];
            else if (reg_addr == tws_pkg::OFS_RX_PTR) rx_ptr_reg <= reg_wdata[PTR_W-1:0];
            else if (reg_addr == tws_pkg::OFS_TX_PTR) tx_ptr_reg <= reg_wdata[PTR_W-1:0];
            else if (reg_addr == tws_pkg::OFS_RX_MAX) rx_max_reg <= reg_wdata[CNT_W-1:0];
            else if (reg_addr == tws_pkg::OFS_TX_MAX) tx_max_reg <= reg_wdata[CNT_W-1:0];
        end
    end

    // event flags: hardware set wins over a software clear in the same cycle
    wire ev_write = reg_write && (reg_addr == tws_pkg::OFS_EVENTS);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) events_reg <= 6'h00;
        else events_reg <= (ev_write ? (events_reg & ~reg_wdata[5:0]) : events_reg) | ev_pulse_reg;
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    wire [31:0] rd_mux =
        (reg_addr == tws_pkg::OFS_ENABLE) ? {28'h000_0000, enable_reg ? tws_pkg::ENABLE_ON : 4'h0} :
        (reg_addr == tws_pkg::OFS_EVENTS) ? {26'h000_0000, events_reg} :
        (reg_addr == tws_pkg::OFS_MATCH) ? {31'h0000_0000, match_reg} :
        (reg_addr == tws_pkg::OFS_ADDR0) ? {25'h000_0000, addr0_reg} :
        (reg_addr == tws_pkg::OFS_ADDR1) ? {25'h000_0000, addr1_reg} :
        (reg_addr == tws_pkg::OFS_CONFIG) ? {30'h0000_0000, config_reg} :
        (reg_addr == tws_pkg::OFS_ORC) ? {24'h00_0000, orc_reg} :
        (reg_addr == tws_pkg::OFS_SHORTS) ? {30'h0000_0000, shorts_reg} :
        (reg_addr == tws_pkg::OFS_RX_PTR) ? 32'(rx_ptr_reg) :
        (reg_addr == tws_pkg::OFS_TX_PTR) ? 32'(tx_ptr_reg) :
        (reg_addr == tws_pkg::OFS_RX_MAX) ? 32'(rx_max_reg) :
        (reg_addr == tws_pkg::OFS_TX_MAX) ? 32'(tx_max_reg) :
        (reg_addr == tws_pkg::OFS_RX_TOTAL) ? 32'(rx_total_reg) :
        (reg_addr == tws_pkg::OFS_TX_TOTAL) ? 32'(tx_total_reg) : tws_pkg::RST_ZERO;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) reg_rdata <= tws_pkg::RST_ZERO;
        else if (reg_read) reg_rdata <= rd_mux;
        else reg_rdata <= tws_pkg::RST_ZERO;
    end

    // ready flags; clearing on begin wins over nothing, prepare in same cycle stays
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_ready_reg <= 1'b0;
            rx_ready_reg <= 1'b0;
        end else begin
            if (wr_prep_tx) tx_ready_reg <= 1'b1;
            else if (ev_pulse_reg[tws_pkg::EV_TX_BEGUN]) tx_ready_reg <= 1'b0;
            else if (ev_pulse_reg[tws_pkg::EV_STOPPED] && dir_read_reg) tx_ready_reg <= 1'b0;
            if (wr_prep_rx) rx_ready_reg <= 1'b1;
            else if (ev_pulse_reg[tws_pkg::EV_RX_BEGUN]) rx_ready_reg <= 1'b0;
            else if (ev_pulse_reg[tws_pkg::EV_STOPPED] && !dir_read_reg) rx_ready_reg <= 1'b0;
        end
    end

    // main sequencer: bit shifting on scl edges, memory access between bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= tws_pkg::TWS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            dir_read_reg <= 1'b0;
            suspended_reg <= 1'b0;
            cur_ptr_reg <= '0;
            cur_max_reg <= '0;
            count_reg <= '0;
            rx_total_reg <= '0;
            tx_total_reg <= '0;
            sda_hold_reg <= 1'b0;
            scl_hold_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
            ev_pulse_reg <= 6'h00;
            match_reg <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 8'h00;
        end else begin
            ev_pulse_reg <= 6'h00;
            if (mem_req_reg && mem_ack) begin
                mem_req_reg <= 1'b0;
                if (!mem_we_reg) tx_byte_reg <= mem_rdata;
            end
            if (wr_suspend || (shorts_reg[0] && ev_pulse_reg[tws_pkg::EV_READ])) suspended_reg <= 1'b1;
            else if (wr_resume) suspended_reg <= 1'b0;
            if (!enable_reg) begin
                state_reg <= tws_pkg::TWS_IDLE;
                sda_hold_reg <= 1'b0;
                scl_hold_reg <= 1'b0;
                pend_stop_reg <= 1'b0;
            end else if (in_frame && (pend_stop_reg || bus_stop || wr_stop)) begin
                // stopped waits for any memory access in flight
                sda_hold_reg <= 1'b0;
                scl_hold_reg <= 1'b0;
                pend_stop_reg <= !finish;
                if (finish) begin
                    state_reg <= tws_pkg::TWS_IDLE;
                    ev_pulse_reg[tws_pkg::EV_STOPPED] <= 1'b1;
                    if (dir_read_reg) tx_total_reg <= count_reg;
                    else rx_total_reg <= count_reg;
                end
            end else if (bus_start) begin
                // start from idle or skip goes to address; a repeated start in any other state returns to idle first
                state_reg <= (state_reg == tws_pkg::TWS_IDLE || state_reg == tws_pkg::TWS_SKIP) ?
                    tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
                bit_cnt_reg <= 4'h0;
                sda_hold_reg <= 1'b0;
                scl_hold_reg <= 1'b0;
            end else begin
                case (state_reg)
                    tws_pkg::TWS_ADDR: begin
                        if (scl_rise && bit_cnt_reg < 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (addr_hit) begin
                                sda_hold_reg <= 1'b1;
                                dir_read_reg <= shift_reg[0];
                                match_reg <= !hit0;
                                ev_pulse_reg[shift_reg[0] ? tws_pkg::EV_READ : tws_pkg::EV_WRITE] <= 1'b1;
                                bit_cnt_reg <= 4'h9;
                            end else begin
                                state_reg <= tws_pkg::TWS_SKIP; // nack by leaving sda high
                            end
                        end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                            sda_hold_reg <= 1'b0;
                            scl_hold_reg <= 1'b1;
                            state_reg <= tws_pkg::TWS_WAIT;
                        end
                    end
                    tws_pkg::TWS_WAIT: begin
                        // stretch until the right side is prepared and not suspended
                        scl_hold_reg <= 1'b1;
                        if (can_go && !suspended_reg) begin
                            state_reg <= tws_pkg::TWS_ACTIVE;
                            ev_pulse_reg[dir_read_reg ? tws_pkg::EV_TX_BEGUN : tws_pkg::EV_RX_BEGUN] <= 1'b1;
                            cur_ptr_reg <= dir_read_reg ? tx_ptr_reg : rx_ptr_reg;
                            cur_max_reg <= dir_read_reg ? tx_max_reg : rx_max_reg;
                            count_reg <= '0;
                            bit_cnt_reg <= 4'h0;
                            mem_req_reg <= dir_read_reg && (tx_max_reg != '0);
                            mem_we_reg <= 1'b0;
                            mem_addr <= tx_ptr_reg;
                            tx_byte_reg <= orc_reg;
                        end
                    end
                    tws_pkg::TWS_ACTIVE: begin
                        // hold scl low while memory or a suspend is pending
                        scl_hold_reg <= mem_req_reg || suspended_reg;
                        if (dir_read_reg) begin
                            if (!scl_reg && bit_cnt_reg < 4'h8 && !mem_req_reg) begin
                                sda_hold_reg <= !tx_byte_reg[3'(7 - bit_cnt_reg)];
                            end
                            if (scl_fall && bit_cnt_reg < 4'h8) begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                if (bit_cnt_reg == 4'h7) sda_hold_reg <= 1'b0;
                            end else if (scl_rise && bit_cnt_reg == 4'h8) begin
                                // master ack low asks for more, nack ends our driving
                                if (over) ev_pulse_reg[tws_pkg::EV_ERROR] <= 1'b1;
                                count_reg <= count_reg + CNT_W'(1);
                                bit_cnt_reg <= sda_reg ? 4'ha : 4'h9;
                                if (!sda_reg && (count_reg + CNT_W'(1)) < cur_max_reg) begin
                                    mem_req_reg <= 1'b1;
                                    mem_addr <= cur_ptr_reg + PTR_W'(count_reg) + PTR_W'(1);
                                end else if (!sda_reg) begin
                                    tx_byte_reg <= orc_reg;
                                end
                            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                                bit_cnt_reg <= 4'h0;
                            end
                        end else begin
                            if (scl_rise && bit_cnt_reg < 4'h8) begin
                                shift_reg <= {shift_reg[6:0], sda_reg};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                                if (!over) begin
                                    sda_hold_reg <= 1'b1;
                                    // stretch at once, the pin path is too slow to wait for mem_req
                                    scl_hold_reg <= 1'b1;
                                    mem_req_reg <= 1'b1;
                                    mem_we_reg <= 1'b1;
                                    mem_addr <= cur_ptr_reg + PTR_W'(count_reg);
                                    mem_wdata <= shift_reg;
                                    count_reg <= count_reg + CNT_W'(1);
                                end else begin
                                    ev_pulse_reg[tws_pkg::EV_ERROR] <= 1'b1;
                                end
                                bit_cnt_reg <= 4'h9;
                            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                                sda_hold_reg <= 1'b0;
                                bit_cnt_reg <= 4'h0;
                            end
                        end
                    end
                    default: begin
                        // idle or ignoring a transfer meant for another slave
                        sda_hold_reg <= 1'b0;
                        scl_hold_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pin enables and memory outputs straight from flip-flops; pin levels tied low
    assign sda_out = 1'b0;
    assign sda_oe = sda_hold_reg;
    assign scl_out = 1'b0;
    assign scl_oe = scl_hold_reg;
    assign mem_req = mem_req_reg;
    assign mem_we = mem_we_reg;
    assign event_pulse = ev_pulse_reg;
endmodule
`default_nettype wire

/* hw/tws_pkg.sv */
// package for the two-wire slave unit: register map, reset values, states
package tws_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_TASK_STOP = 12'h0014;
    localparam logic [11:0] OFS_TASK_SUSPEND = 12'h001c;
    localparam logic [11:0] OFS_TASK_RESUME = 12'h0020;
    localparam logic [11:0] OFS_TASK_PREP_RX = 12'h0030;
    localparam logic [11:0] OFS_TASK_PREP_TX = 12'h0034;
    localparam logic [11:0] OFS_EVENTS = 12'h0100;
    localparam logic [11:0] OFS_SHORTS = 12'h0200;
    localparam logic [11:0] OFS_MATCH = 12'h04d4;
    localparam logic [11:0] OFS_ENABLE = 12'h0500;
    localparam logic [11:0] OFS_RX_PTR = 12'h0534;
    localparam logic [11:0] OFS_RX_MAX = 12'h0538;
    localparam logic [11:0] OFS_RX_TOTAL = 12'h053c;
    localparam logic [11:0] OFS_TX_PTR = 12'h0544;
    localparam logic [11:0] OFS_TX_MAX = 12'h0548;
    localparam logic [11:0] OFS_TX_TOTAL = 12'h054c;
    localparam logic [11:0] OFS_ADDR0 = 12'h0588;
    localparam logic [11:0] OFS_ADDR1 = 12'h058c;
    localparam logic [11:0] OFS_CONFIG = 12'h0594;
    localparam logic [11:0] OFS_ORC = 12'h05c0;
    // event bit positions in the event register
    localparam int EV_STOPPED = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_RX_BEGUN = 2;
    localparam int EV_TX_BEGUN = 3;
    localparam int EV_WRITE = 4;
    localparam int EV_READ = 5;
    localparam int EV_COUNT = 6;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] RST_CONFIG = 2'h1;
    // enable register value that turns the unit on
    localparam logic [3:0] ENABLE_ON = 4'h9;
    // unit states, gray coded along idle, address, stretch, active, skip
    typedef enum logic [2:0] {
        TWS_IDLE = 3'b000,
        TWS_ADDR = 3'b001,
        TWS_WAIT = 3'b011,
        TWS_ACTIVE = 3'b010,
        TWS_SKIP = 3'b110
    } tws_state_t;
endpackage

/* tb/tws_slave_assertions.sv */
// concurrent checks on the two-wire slave unit ports
`timescale 1ns/1ps
`default_nettype none
module tws_slave_assertions #(parameter int ADDR_W = 12, parameter int PTR_W = 32, parameter int CNT_W = 14) (
    // clock and reset
    input wire logic clk, reset_n,
    // bus pin drives
    input wire logic scl_out, sda_out, sda_oe,
    // memory port and events
    input wire logic mem_req, mem_we, mem_ack,
    input wire logic [PTR_W-1:0] mem_addr,
    input wire logic [5:0] event_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // open drain: the unit may only ever pull a line low
    open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("bus line driven high");
    ack_event_a: assert property (event_pulse[tws_pkg::EV_READ] || event_pulse[tws_pkg::EV_WRITE] |-> ##[0:6] sda_oe)
        else $error("command event without acknowledge");
    pulse_single_a: assert property ((event_pulse & $past(event_pulse)) == 6'h0)
        else $error("event pulse longer than one cycle");
    // memory requests hold still until served, then drop
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    mem_drop_a: assert property (mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    stop_idle_a: assert property (event_pulse[tws_pkg::EV_STOPPED] |-> !mem_req)
        else $error("stopped while memory busy");
    begun_excl_a: assert property (!(event_pulse[tws_pkg::EV_RX_BEGUN] && event_pulse[tws_pkg::EV_TX_BEGUN]))
        else $error("both directions begun at once");
    rx_begun_idle_a: assert property (event_pulse[tws_pkg::EV_RX_BEGUN] |-> !mem_req)
        else $error("memory access open at receive begin");
endmodule
bind tws_slave tws_slave_assertions #(.ADDR_W(ADDR_W), .PTR_W(PTR_W), .CNT_W(CNT_W)) chk (.clk(clk),
    .reset_n(reset_n), .scl_out(scl_out), .sda_out(sda_out), .sda_oe(sda_oe), .mem_req(mem_req),
    .mem_we(mem_we), .mem_ack(mem_ack), .mem_addr(mem_addr), .event_pulse(event_pulse));
`default_nettype wire

/* tb/tws_bus_master.sv */
// behavioural single bus master with an 80 ns bus clock
`timescale 1ns/1ps
`default_nettype none
module tws_bus_master (
    // resolved bus lines
    input wire logic scl, sda,
    // pull-down enables of this master
    output logic scl_pull, sda_pull
);
    // sole master on the bus, so no arbitration is attempted
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // releasing scl waits while the slave stretches it; low 50 ns so the slave can stretch in time
    task automatic put(input logic b);
        sda_pull = !b;
        #30 scl_pull = 1'b0;
        wait (scl);
        #30 scl_pull = 1'b1;
        #20;
    endtask
    task automatic get(output logic b);
        sda_pull = 1'b0;
        #30 scl_pull = 1'b0;
        wait (scl);
        #20 b = sda;
        #10 scl_pull = 1'b1;
        #20;
    endtask
    // also serves as repeated start when scl is low
    task automatic start();
        sda_pull = 1'b0;
        #20 scl_pull = 1'b0;
        wait (scl);
        #40 sda_pull = 1'b1;
        #40 scl_pull = 1'b1;
        #20;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #20 scl_pull = 1'b0;
        wait (scl);
        #40 sda_pull = 1'b0;
        #80;
    endtask
    // msb first, then the slave's answer bit
    task automatic wbyte(input logic [7:0] v, output logic nak);
        for (int i = 7; i >= 0; i--) put(v[i]);
        get(nak);
    endtask
    // the caller nacks the last wanted byte
    task automatic rbyte(output logic [7:0] v, input logic nak);
        for (int i = 7; i >= 0; i--) get(v[i]);
        put(nak);
    endtask
endmodule
`default_nettype wire

/* tb/tws_slave_test.sv */
// self-checking bench for the two-wire slave unit
`timescale 1ns/1ps
`default_nettype none
module tws_slave_test;
    logic clk, reset_n, reg_write, reg_read, mem_ack, rd_d, nak, scl_oe, sda_oe, m_scl, m_sda, mem_req, mem_we;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, exp_q[$], mem_q[$];
    logic [7:0] mem_rdata, mem_wdata, d;
    logic [5:0] event_pulse;
    wire logic scl = !(scl_oe || m_scl); // pull-ups win when nobody pulls
    wire logic sda = !(sda_oe || m_sda);
    int mismatches = 0;
    int checks = 0;
    tws_slave dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .event_pulse(event_pulse));
    tws_bus_master m (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one register access plus an idle cycle, so strobes never collide
    task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] v);
        if (!we) exp_q.push_back(v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= we;
        reg_read <= !we;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    // whole run needs about 1k cycles; 20k means a hang
    initial begin
        #200_000;
        mismatches++;
        complete_run();
    end
    // memory with random latency; results compared against the oldest note
    always @(posedge clk) begin
        rd_d <= reg_read;
        mem_ack <= mem_req && !mem_ack && ($urandom_range(1) == 1);
        mem_rdata <= mem_addr[7:0] ^ 8'h5c;
        if (rd_d) check(reg_rdata, exp_q.pop_front());
        if (mem_req && mem_we && mem_ack) check({mem_addr[23:0], mem_wdata}, mem_q.pop_front());
    end
    initial begin
        {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        d = 8'($urandom(32'h733eceae));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1'b1, tws_pkg::OFS_ADDR0, 32'h0000_002a);
        bus(1'b1, tws_pkg::OFS_ADDR1, 32'h0000_0035);
        bus(1'b1, tws_pkg::OFS_CONFIG, 32'h0000_0003);
        bus(1'b1, tws_pkg::OFS_ENABLE, {28'h0, tws_pkg::ENABLE_ON});
        bus(1'b0, tws_pkg::OFS_CONFIG, 32'h0000_0003);
        bus(1'b0, 12'h0ff0, 32'h0000_0000); // unmapped reads as zero
        bus(1'b1, tws_pkg::OFS_RX_PTR, 32'h0000_0100);
        bus(1'b1, tws_pkg::OFS_RX_MAX, 32'h0000_0002);
        bus(1'b1, tws_pkg::OFS_TASK_PREP_RX, 32'h0000_0001);
        // write to address 0 with one byte past the limit
        m.start();
        m.wbyte(8'h54, nak);
        check(nak, 1'b0);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            if (i < 2) mem_q.push_back({24'h00_0100 + 24'(i), d});
            m.wbyte(d, nak);
            check(nak, i == 2);
        end
        m.stop();
        repeat (30) @(posedge clk);
        bus(1'b0, tws_pkg::OFS_EVENTS, 32'h0000_0017); // stopped, error, rx begun, write
        bus(1'b1, tws_pkg::OFS_EVENTS, 32'h0000_003f);
        check(32'(mem_q.size()), 32'h0000_0000);
        bus(1'b1, tws_pkg::OFS_TX_PTR, 32'h0000_0200);
        bus(1'b1, tws_pkg::OFS_TX_MAX, 32'h0000_0001);
        bus(1'b1, tws_pkg::OFS_ORC, 32'h0000_00a5);
        // read from address 1 before transmit is prepared, reading one byte too many
        fork
            begin
                m.start();
                m.wbyte(8'h6b, nak);
                check(nak, 1'b0);
                m.rbyte(d, 1'b0);
                check(d, 8'h5c);
                m.rbyte(d, 1'b1);
                check(d, 8'ha5);
                m.stop();
            end
            begin
                repeat (300) @(posedge clk);
                @(negedge clk);
                check(scl_oe, 1'b1);
                @(posedge clk);
                bus(1'b1, tws_pkg::OFS_TASK_PREP_TX, 32'h0000_0001);
            end
        join
        repeat (30) @(posedge clk);
        bus(1'b0, tws_pkg::OFS_EVENTS, 32'h0000_002b); // stopped, error, tx begun, read
        // an address nobody listens to is not acknowledged
        m.start();
        m.wbyte(8'h22, nak);
        check(nak, 1'b1);
        m.stop();
        repeat (20) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
